// ===== hw/ramp_segment_sequencer.sv
// Ramp segment sequencer: per-segment settings, tick pacing and segment advance
// Notes on behaviour
// - Slow tick doubles clocks per ramp tick
// - Length counts ticks; one to 65536
// - Flag code drives two flags at segment start
// - Accumulator clear at segment start when set
// - Advance event: length, trigger A, B, C
// - Next segment taken from next-index field
// - Eight independent segment setting sets
// - Fast settle output follows active segment bit
//
// Chosen here: the placing of the registers and the plain strobed port.
module ramp_segment_sequencer
  import ramp_seq_pkg::*;
#(
  parameter int NSEG = SEG_COUNT
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire reg_req_t          req,
  output logic [DATA_W-1:0]      rdata_ff,
  input  wire logic [2:0]        trig_pins,
  output logic                   general_flag_lo_ff,
  output logic                   general_flag_hi_ff,
  output logic                   fast_settle_ff,
  output logic [ACC_W-1:0]       ramp_acc_ff,
  output logic [SEG_IDX_W-1:0]   active_seg_ff,
  output logic                   running_ff
);
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_RUN} seq_state_t;

  seg_cfg_t               cfg_ff [NSEG];
  seq_state_t             state_ff;
  logic [LEN_W:0]         len_cnt_ff;
  logic                   half_ff;
  logic                   run_en_ff;
  logic [SEG_IDX_W-1:0]   start_idx_ff;
  logic [2:0]             trig_level;
  logic [2:0]             trig_prev_ff;
  logic [2:0]             trig_rise;
  seg_cfg_t               cur;
  logic                   tick;
  logic                   len_done;
  logic                   advance;
  logic                   event_hit;

  // Segment register index decode
  function automatic logic seg_hit(input logic [ADDR_W-1:0] a);
    seg_hit = (a < ADDR_W'(2 * NSEG));
  endfunction

  trig_sync #(.WIDTH(3)) trig_sync_i (
    .clk      (clk),
    .rst      (rst),
    .async_in (trig_pins),
    .sync_out (trig_level)
  );

  // Trigger edge detect on synchronised levels
  always_ff @(posedge clk) begin
    if (rst) trig_prev_ff <= '0;
    else     trig_prev_ff <= trig_level;
  end
  assign trig_rise = trig_level & ~trig_prev_ff;

  // Per-segment settings storage, all cleared at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NSEG; i++) cfg_ff[i] <= '0;
    end else if (req.wr && seg_hit(req.addr)) begin
      if (req.addr[0] == 1'b0) begin
        cfg_ff[req.addr[SEG_IDX_W:1]].segment_increment <= req.wdata[INC_W-1:0];
      end else begin
        cfg_ff[req.addr[SEG_IDX_W:1]].segment_length        <= req.wdata[LEN_LSB +: LEN_W];
        cfg_ff[req.addr[SEG_IDX_W:1]].segment_slow_tick     <= req.wdata[SLOW_BIT];
        cfg_ff[req.addr[SEG_IDX_W:1]].segment_flag_code     <= req.wdata[FLAG_LSB +: 2];
        cfg_ff[req.addr[SEG_IDX_W:1]].segment_acc_clear     <= req.wdata[CLR_BIT];
        cfg_ff[req.addr[SEG_IDX_W:1]].segment_advance_event <= req.wdata[EVT_LSB +: 2];
        cfg_ff[req.addr[SEG_IDX_W:1]].segment_next_index    <= req.wdata[NEXT_LSB +: SEG_IDX_W];
        cfg_ff[req.addr[SEG_IDX_W:1]].segment_fast_settle   <= req.wdata[FAST_BIT];
      end
    end
  end

  // Control register: run enable and start segment
  always_ff @(posedge clk) begin
    if (rst) begin
      run_en_ff    <= 1'b0;
      start_idx_ff <= '0;
    end else if (req.wr && req.addr == CTRL_ADDR) begin
      run_en_ff    <= req.wdata[CTRL_RUN_BIT];
      start_idx_ff <= req.wdata[CTRL_START_LSB +: SEG_IDX_W];
    end
  end

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= REG_RESET;
    end else if (req.rd) begin
      if (seg_hit(req.addr)) begin
        if (req.addr[0] == 1'b0) begin
          rdata_ff <= DATA_W'(cfg_ff[req.addr[SEG_IDX_W:1]].segment_increment);
        end else begin
          rdata_ff <= DATA_W'({cfg_ff[req.addr[SEG_IDX_W:1]].segment_fast_settle,
                               cfg_ff[req.addr[SEG_IDX_W:1]].segment_next_index,
                               cfg_ff[req.addr[SEG_IDX_W:1]].segment_advance_event,
                               cfg_ff[req.addr[SEG_IDX_W:1]].segment_acc_clear,
                               cfg_ff[req.addr[SEG_IDX_W:1]].segment_flag_code,
                               cfg_ff[req.addr[SEG_IDX_W:1]].segment_slow_tick,
                               cfg_ff[req.addr[SEG_IDX_W:1]].segment_length});
        end
      end else if (req.addr == CTRL_ADDR) begin
        rdata_ff <= DATA_W'({start_idx_ff, run_en_ff});
      end else if (req.addr == STATUS_ADDR) begin
        rdata_ff <= DATA_W'({fast_settle_ff, general_flag_hi_ff, general_flag_lo_ff,
                             active_seg_ff, running_ff});
      end else if (req.addr == ACC_ADDR) begin
        rdata_ff <= ramp_acc_ff[DATA_W-1:0];
      end else begin
        rdata_ff <= REG_RESET; // Unmapped reads as zero
      end
    end
  end

  // Active segment settings and event decode
  assign cur      = cfg_ff[active_seg_ff];
  assign tick     = (state_ff == ST_RUN) && (!cur.segment_slow_tick || half_ff);
  assign len_done = tick && (len_cnt_ff <= (LEN_W+1)'(1));
  always_comb begin
    case (cur.segment_advance_event)
      EVT_LENGTH: event_hit = len_done;
      EVT_TRIG_A: event_hit = trig_rise[0];
      EVT_TRIG_B: event_hit = trig_rise[1];
      EVT_TRIG_C: event_hit = trig_rise[2];
      default:    event_hit = 1'b0;
    endcase
  end
  assign advance = (state_ff == ST_RUN) && event_hit;

  // Sequencer state and active segment index
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff      <= ST_IDLE;
      active_seg_ff <= '0;
      running_ff    <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (run_en_ff) begin
            active_seg_ff <= start_idx_ff;
            state_ff      <= ST_START;
          end
        end
        ST_START: state_ff <= run_en_ff ? ST_RUN : ST_IDLE;
        ST_RUN: begin
          if (!run_en_ff) begin
            state_ff <= ST_IDLE;
          end else if (advance) begin
            active_seg_ff <= cur.segment_next_index;
            state_ff      <= ST_START;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
      running_ff <= run_en_ff;
    end
  end

  // Half-rate phase for slow ticks; restarts low outside the run state
  always_ff @(posedge clk) begin
    if (rst) begin
      half_ff <= 1'b0;
    end else if (state_ff == ST_RUN) begin
      half_ff <= cur.segment_slow_tick ? ~half_ff : 1'b0;
    end else begin
      half_ff <= 1'b0;
    end
  end

  // Length counter: loaded at segment start, one step down per tick
  always_ff @(posedge clk) begin
    if (rst) begin
      len_cnt_ff <= '0;
    end else if (state_ff == ST_START) begin
      // Zero length field means the 65536 maximum
      len_cnt_ff <= (cur.segment_length == '0) ? {1'b1, {LEN_W{1'b0}}}
                                               : {1'b0, cur.segment_length};
    end else if (tick && len_cnt_ff != '0) begin
      len_cnt_ff <= len_cnt_ff - (LEN_W+1)'(1);
    end
  end

  // General flags set at segment start and held until the next start
  always_ff @(posedge clk) begin
    if (rst) begin
      general_flag_lo_ff <= 1'b0;
      general_flag_hi_ff <= 1'b0;
    end else if (state_ff == ST_START) begin
      general_flag_lo_ff <= cur.segment_flag_code[0];
      general_flag_hi_ff <= cur.segment_flag_code[1];
    end
  end

  // Fast settle follows the active segment and drops once idle
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_settle_ff <= 1'b0;
    end else if (state_ff == ST_START) begin
      fast_settle_ff <= cur.segment_fast_settle;
    end else if (state_ff == ST_IDLE) begin
      fast_settle_ff <= 1'b0;
    end
  end

  // Ramp accumulator: optional clear at start, signed add per counted tick
  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_acc_ff <= '0;
    end else if (state_ff == ST_START && cur.segment_acc_clear) begin
      ramp_acc_ff <= '0;
    end else if (tick && len_cnt_ff != '0) begin
      ramp_acc_ff <= ramp_acc_ff + ACC_W'($signed(cur.segment_increment));
    end
  end
endmodule

// ===== inc/ramp_seq_pkg.sv
// Package: constants and types for the ramp segment sequencer
package ramp_seq_pkg;
  localparam int SEG_COUNT     = 8;
  localparam int SEG_IDX_W     = 3;
  localparam int INC_W         = 30;
  localparam int LEN_W         = 16;
  localparam int ACC_W         = 33;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  // Register map: per segment, word A at 0x00+i*2, word B at 0x01+i*2
  localparam logic [ADDR_W-1:0] SEG_BASE_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL_ADDR     = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_ADDR   = 8'h11;
  localparam logic [ADDR_W-1:0] ACC_ADDR      = 8'h12;
  // Word B field positions
  localparam int LEN_LSB       = 0;
  localparam int SLOW_BIT      = 16;
  localparam int FLAG_LSB      = 17;
  localparam int CLR_BIT       = 19;
  localparam int EVT_LSB       = 20;
  localparam int NEXT_LSB      = 22;
  localparam int FAST_BIT      = 25;
  // Control register fields
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_START_LSB = 1;
  // Advance event codes
  localparam logic [1:0] EVT_LENGTH = 2'h0;
  localparam logic [1:0] EVT_TRIG_A = 2'h1;
  localparam logic [1:0] EVT_TRIG_B = 2'h2;
  localparam logic [1:0] EVT_TRIG_C = 2'h3;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

  typedef struct packed {
    logic                 segment_fast_settle;
    logic [SEG_IDX_W-1:0] segment_next_index;
    logic [1:0]           segment_advance_event;
    logic                 segment_acc_clear;
    logic [1:0]           segment_flag_code;
    logic                 segment_slow_tick;
    logic [LEN_W-1:0]     segment_length;
    logic [INC_W-1:0]     segment_increment;
  } seg_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;
endpackage

// ===== hw/trig_sync.sv
// Two-stage synchroniser for the three external trigger pins
module trig_sync
  import ramp_seq_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

// ===== testbench/ramp_segment_sequencer_assertions.sv
// Checker: port-level properties of the ramp segment sequencer
module ramp_segment_sequencer_checker
  import ramp_seq_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire reg_req_t             req,
  input wire logic [DATA_W-1:0]    rdata_ff,
  input wire logic [2:0]           trig_pins,
  input wire logic                 general_flag_lo_ff,
  input wire logic                 general_flag_hi_ff,
  input wire logic                 fast_settle_ff,
  input wire logic [ACC_W-1:0]     ramp_acc_ff,
  input wire logic [SEG_IDX_W-1:0] active_seg_ff,
  input wire logic                 running_ff
);
  logic [6:0]  status_now;
  logic [31:0] acc_lo;
  // Status word and accumulator view as the bus returns them
  assign status_now = {fast_settle_ff, general_flag_hi_ff, general_flag_lo_ff,
                       active_seg_ff, running_ff};
  assign acc_lo = ramp_acc_ff[31:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_reset_core: assert property ($fell(rst) |-> ramp_acc_ff == '0
    && active_seg_ff == '0 && !running_ff) else $error("state not cleared by reset");
  chk_reset_flags: assert property ($fell(rst) |-> !general_flag_lo_ff
    && !general_flag_hi_ff && !fast_settle_ff) else $error("flags not cleared by reset");
  chk_unmapped_read: assert property (req.rd && req.addr > ACC_ADDR
    |=> rdata_ff == '0) else $error("unmapped read not zero");
  chk_status_read: assert property (req.rd && req.addr == STATUS_ADDR
    |=> rdata_ff[6:0] == $past(status_now)) else $error("status read wrong");
  chk_acc_read: assert property (req.rd && req.addr == ACC_ADDR
    |=> rdata_ff == $past(acc_lo)) else $error("accumulator read wrong");
  chk_idle_acc: assert property (!running_ff [*4] |-> $stable(ramp_acc_ff))
    else $error("accumulator moved while idle");
  chk_idle_flags: assert property (!running_ff [*4] |-> $stable(general_flag_lo_ff)
    && $stable(general_flag_hi_ff)) else $error("flags moved while idle");
  chk_idle_fast: assert property (!running_ff [*4] |-> !fast_settle_ff)
    else $error("fast settle on while idle");
endmodule

bind ramp_segment_sequencer ramp_segment_sequencer_checker ramp_segment_sequencer_checker_i (
  .clk(clk), .rst(rst), .req(req), .rdata_ff(rdata_ff), .trig_pins(trig_pins),
  .general_flag_lo_ff(general_flag_lo_ff), .general_flag_hi_ff(general_flag_hi_ff),
  .fast_settle_ff(fast_settle_ff), .ramp_acc_ff(ramp_acc_ff),
  .active_seg_ff(active_seg_ff), .running_ff(running_ff));

// ===== testbench/test_ramp_segment_sequencer.sv
// Testbench: register access, segment sequencing and trigger advance
module test_ramp_segment_sequencer
  import ramp_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  logic [2:0] trig_pins = 3'h0;
  logic [DATA_W-1:0] rdata_ff;
  logic lo, hi, fast, running_ff;
  logic [ACC_W-1:0] acc;
  logic [SEG_IDX_W-1:0] seg;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  always #2.5 clk = ~clk;
  ramp_segment_sequencer ramp_segment_sequencer_i (.clk(clk), .rst(rst), .req(req),
    .rdata_ff(rdata_ff), .trig_pins(trig_pins), .general_flag_lo_ff(lo),
    .general_flag_hi_ff(hi), .fast_settle_ff(fast), .ramp_acc_ff(acc),
    .active_seg_ff(seg), .running_ff(running_ff));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Bus cycles: one-cycle strobes, read data checked in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(rdata_ff, e);
  endtask
  // Counts cycles until a segment becomes active; gives up after a bound
  task automatic wait_seg(input logic [2:0] s);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (seg !== s && n < 300);
    if (n >= 300) begin
      bad_count++;
      summarize();
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 20; a++) rd(8'(a), '0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, '0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(8'(2 * i), i == 7 ? 32'hFFFF_FFFF : 32'(i + 1));
      wr(8'(2 * i + 1), {7'h00, 3'(i), 2'(i), 17'h00000, 3'(i)});
    end
    for (int i = 0; i < 8; i++) begin
      rd(8'(2 * i), i == 7 ? 32'h3FFF_FFFF : 32'(i + 1));
      rd(8'(2 * i + 1), {7'h00, 3'(i), 2'(i), 17'h00000, 3'(i)});
    end
    $display("test registers done");
    // Seg0: len 2, flag 1, clear; seg1: len 3, slow, flag 2, fast settle
    wr(8'h00, 32'h0000_0001);
    wr(8'h01, 32'h004A_0002);
    wr(8'h02, 32'h0000_0002);
    wr(8'h03, 32'h0205_0003);
    wr(CTRL_ADDR, 32'h0000_0001);
    wait_seg(3'h1);
    check(acc, 33'h2);
    check({hi, lo, fast}, 3'h2);
    wait_seg(3'h0);
    check(n, 7);
    check(acc, 33'h8);
    check({hi, lo, fast}, 3'h5);
    wait_seg(3'h1);
    check(n, 3);
    check(acc, 33'h2);
    wr(CTRL_ADDR, 32'h0);
    $display("test length mode done");
    // Seg2 waits for trigger k; another pin must not advance it
    for (int k = 1; k < 4; k++) begin
      wr(8'h05, 32'h00C0_0001 | (32'(k) << 20));
      wr(8'h07, 32'h00C0_0001);
      wr(CTRL_ADDR, 32'h0000_0005);
      trig_pins <= 3'(1 << (k % 3));
      repeat (8) @(posedge clk);
      #1;
      check(seg, 3'h2);
      @(posedge clk);
      trig_pins <= 3'h0;
      repeat (2) @(posedge clk);
      trig_pins <= 3'(1 << (k - 1));
      wait_seg(3'h3);
      check(n <= 8, 1'b1);
      @(posedge clk);
      trig_pins <= 3'h0;
      wr(CTRL_ADDR, 32'h0);
    end
    $display("test trigger done");
    // Seg7 alone: increment minus one, clear at each start, length 3
    wr(8'h0F, 32'h01C8_0003);
    wr(CTRL_ADDR, 32'h0000_000F);
    repeat (5) @(posedge clk);
    #1;
    check(acc, 33'h1_FFFF_FFFD);
    check({running_ff, seg}, 4'hF);
    wr(CTRL_ADDR, 32'h0);
    $display("test signed increment done");
    summarize();
  end
endmodule
